// ===== bench/bms_mem_model.sv
/*
  bms_mem_model: system memory behind both channel memory ports.
  assumes: requests are held until ack; answers change at the falling edge.
*/
`timescale 1ns/100ps
module bms_mem_model
  import bms_pkg::*;
(
  input  wire logic                         core_clk_i,
  input  wire logic [bms_pkg::N_CH-1:0]       mem_req_i,
  input  wire logic [bms_pkg::N_CH-1:0]       mem_we_i,
  input  wire logic [bms_pkg::N_CH-1:0][31:0] mem_addr_i,
  input  wire logic [bms_pkg::N_CH-1:0][31:0] mem_wdata_i,
  output logic      [bms_pkg::N_CH-1:0]       mem_ack_o,
  output logic      [bms_pkg::N_CH-1:0]       mem_err_o,
  output logic      [bms_pkg::N_CH-1:0][31:0] mem_rdata_o
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] err_addr [N_CH];
  logic [31:0] addr_log [N_CH][$];
  int          lat = 0;
  int          wait_cnt [N_CH];

  initial begin
    mem_ack_o = '0;
    mem_err_o = '0;
    mem_rdata_o = '0;
    for (int c = 0; c < N_CH; c++) begin
      err_addr[c] = 32'hffff_ffff;
      wait_cnt[c] = 0;
    end
  end

  always @(negedge core_clk_i) begin
    for (int c = 0; c < N_CH; c++) begin
      mem_ack_o[c] <= 1'b0;
      mem_err_o[c] <= 1'b0;
      // idle data bus toggles so a stale word is never mistaken for an answer
      mem_rdata_o[c] <= ~mem_rdata_o[c];
      if (mem_req_i[c] && !mem_ack_o[c]) begin
        if (wait_cnt[c] < lat) begin
          wait_cnt[c]++;
        end else begin
          wait_cnt[c] = 0;
          addr_log[c].push_back(mem_addr_i[c]);
          mem_ack_o[c] <= 1'b1;
          if (mem_addr_i[c] === err_addr[c]) begin
            mem_err_o[c] <= 1'b1;
          end else if (mem_we_i[c]) begin
            mem[mem_addr_i[c]] = mem_wdata_i[c];
          end else begin
            mem_rdata_o[c] <= mem.exists(mem_addr_i[c]) ? mem[mem_addr_i[c]] : 32'hdead_beef;
          end
        end
      end
    end
  end
endmodule

// ===== bench/ide_bus_master_status_prd_tb_top.sv
/*
  testbench: register and transfer scenarios on both channels, stop on channel 1, error on channel 0.
  assumes: bms_engine and bms_mem_model; inputs change at the falling edge.
*/
`timescale 1ns/100ps
module ide_bus_master_status_prd_tb_top;
  import bms_pkg::*;
  logic                  clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, io_rvalid, hold_rd = 0;
  logic [3:0]            io_addr = '0, io_be = '0;
  logic [31:0]           io_wdata = '0, io_rdata;
  logic [N_CH-1:0]       irq = '0, req, we, ack, err, wr_valid = '0, wr_ready, rd_valid;
  logic [N_CH-1:0]       rd_ready = '0;
  logic [N_CH-1:0][31:0] addr, wdata, rdata, rd_data, wr_data = '0;
  int                    mismatches = 0, total_checks = 0, exp_st[N_CH] = '{0, 0};
  logic [31:0]           got[$];

  always #5 clk = ~clk;

  bms_engine dut_u (.core_clk_i(clk), .reset_n_i(rst_n), .io_addr_i(io_addr), .io_be_i(io_be),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .io_rvalid_o(io_rvalid), .drv_irq_i(irq), .mem_req_o(req), .mem_we_o(we),
    .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_ack_i(ack), .mem_err_i(err),
    .mem_rdata_i(rdata), .drv_wr_data_i(wr_data), .drv_wr_valid_i(wr_valid),
    .drv_wr_ready_o(wr_ready), .drv_rd_data_o(rd_data), .drv_rd_valid_o(rd_valid),
    .drv_rd_ready_i(rd_ready));

  bms_mem_model mem_u (.core_clk_i(clk), .mem_req_i(req), .mem_we_i(we), .mem_addr_i(addr),
    .mem_wdata_i(wdata), .mem_ack_o(ack), .mem_err_o(err), .mem_rdata_o(rdata));

  always @(negedge clk) begin
    logic [N_CH-1:0] nr;
    // a word counts as taken when ready is offered while valid stands into the next edge
    nr = hold_rd ? 2'b00 : 2'($urandom);
    if (rd_valid[1] && nr[1]) got.push_back(rd_data[1]);
    rd_ready <= nr;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobes drop for a full cycle so back-to-back calls never retouch them
  task automatic io_wr_t(logic [3:0] a, logic [3:0] be, logic [31:0] d);
    io_addr = a;
    io_be = be;
    io_wdata = d;
    io_wr = 1;
    @(negedge clk);
    io_wr = 0;
    @(negedge clk);
  endtask

  task automatic io_rd_t(logic [3:0] a, output logic [31:0] d);
    io_addr = a;
    io_rd = 1;
    @(negedge clk);
    io_rd = 0;
    check("rvalid", {31'h0, io_rvalid}, 32'h1);
    d = io_rdata;
    @(negedge clk);
  endtask

  task automatic chk_st(int c);
    logic [31:0] d;
    io_rd_t(4'(c * 8 + 2), d);
    check("status", {24'h0, d[23:16]}, 32'(exp_st[c]));
  endtask

  task automatic wr_st(int c, logic [7:0] v);
    io_wr_t(4'(c * 8 + 2), 4'h4, {8'h0, v, 16'h0});
    exp_st[c] = (exp_st[c] & 'h07 & ~(v & 'h06)) | (v & 'h60);
  endtask

  task automatic wr_cmd(int c, logic [7:0] v);
    io_wr_t(4'(c * 8), 4'h1, {24'h0, v});
    exp_st[c][0] = v[0];
  endtask

  task automatic wait_bit(int c, int b, bit v);
    logic [31:0] d;
    for (int i = 0; i < 300; i++) begin
      io_rd_t(4'(c * 8 + 2), d);
      if (d[16 + b] === v) break;
    end
    exp_st[c][b] = v;
    check("status bit", {31'h0, d[16 + b]}, {31'h0, v});
  endtask

  task automatic desc(logic [31:0] t, logic [31:0] ra, logic [15:0] n, bit end_of_table_flag);
    mem_u.mem[t] = ra;
    mem_u.mem[t + 4] = {end_of_table_flag, 15'h0, n};
  endtask

  task automatic push_wr(int c, logic [31:0] w);
    wr_data[c] = w;
    wr_valid[c] = 1;
    repeat (200) begin
      #1;
      if (wr_ready[c] === 1'b1) break;
      @(negedge clk);
    end
    @(negedge clk);
  endtask

  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] w[$];
    logic [31:0] el[7];
    void'($urandom(32'hdc6e9ef3));
    repeat (5) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    for (int c = 0; c < N_CH; c++) begin
      chk_st(c);
      io_rd_t(4'(c * 8 + 4), d);
      check("ptr reset", d, 32'h0);
      el[0] = $urandom;
      io_wr_t(4'(c * 8 + 4), 4'hf, el[0]);
      io_rd_t(4'(c * 8 + 4), d);
      check("ptr", d, el[0] & 32'hffff_fffc);
      wr_st(c, 8'h66);
      chk_st(c);
      wr_st(c, 8'h00);
      chk_st(c);
    end
    w.delete();
    // drive to memory on channel 0 with slow memory
    mem_u.lat = 2;
    desc(32'h1000, 32'h2_0000, 16'h8, 0);
    desc(32'h1008, 32'h3_0000, 16'h4, 1);
    io_wr_t(4'h4, 4'hf, 32'h1000);
    wr_cmd(0, 8'h08);
    wr_cmd(0, 8'h09);
    chk_st(0);
    repeat (3) begin
      w.push_back($urandom);
      push_wr(0, w[$]);
    end
    wr_valid[0] = 0;
    irq[0] = 1;
    wait_bit(0, 2, 1);
    el = '{32'h1000, 32'h1004, 32'h2_0000, 32'h2_0004, 32'h1008, 32'h100c, 32'h3_0000};
    check("mem 0", mem_u.mem[el[2]], w[0]);
    check("mem 1", mem_u.mem[el[3]], w[1]);
    check("mem 2", mem_u.mem[el[6]], w[2]);
    wait_bit(0, 0, 0);
    check("req count", mem_u.addr_log[0].size(), 7);
    foreach (el[i]) check("req addr", mem_u.addr_log[0][i], el[i]);
    irq[0] = 0;
    wr_st(0, 8'h04);
    chk_st(0);
    wr_cmd(0, 8'h08);
    // memory to drive on channel 1 with prompt memory
    mem_u.lat = 0;
    w.delete();
    // ten bytes: the odd tail still costs a whole third word
    desc(32'h2000, 32'h4_0000, 16'ha, 1);
    for (int i = 0; i < 3; i++) begin
      w.push_back($urandom);
      mem_u.mem[32'h4_0000 + 4 * i] = w[i];
    end
    io_wr_t(4'hc, 4'hf, 32'h2000);
    wr_cmd(1, 8'h01);
    wait_bit(1, 0, 0);
    for (int i = 0; i < 50 && got.size() < 3; i++) @(negedge clk);
    check("rd count", got.size(), 3);
    foreach (got[i]) check("rd word", got[i], w[i]);
    // stop in mid-region, then restart from the table head
    wr_cmd(1, 8'h00);
    hold_rd = 1;
    desc(32'h3000, 32'h5_0000, 16'h100, 1);
    io_wr_t(4'hc, 4'hf, 32'h3000);
    wr_cmd(1, 8'h01);
    repeat (10) @(negedge clk);
    chk_st(1);
    wr_cmd(1, 8'h00);
    chk_st(1);
    mem_u.addr_log[1].delete();
    wr_cmd(1, 8'h01);
    repeat (5) @(negedge clk);
    check("restart fetch", mem_u.addr_log[1][0], 32'h3000);
    wr_cmd(1, 8'h00);
    hold_rd = 0;
    // failed table fetch on channel 0
    mem_u.err_addr[0] = 32'h1000;
    wr_cmd(0, 8'h09);
    wait_bit(0, 1, 1);
    exp_st[0][0] = 0;
    chk_st(0);
    wr_st(0, 8'h60);
    chk_st(0);
    wr_st(0, 8'h62);
    chk_st(0);
    give_verdict();
  end
endmodule

// ===== hw/bms_engine.sv
/*
  bms_engine: status, descriptor-table pointer and region walker for two
  bus-master disk DMA channels, with an I/O register slave.
  assumes: the I/O window base is decoded outside; each channel has its own
  memory request port (held until ack) and a 32-bit drive data stream.
*/
// Operation
// - status bit 7 reports simplex, read-only
// - drive 1 capable flag, software written
// - drive 0 capable flag, software written
// - drive interrupt rising edge sets flag; write-one clears
// - interrupt flag waits for pending memory writes
// - memory error sets error flag; write-one clears
// - start bit write sets active flag
// - active clears after end-marked region completes
// - clearing start bit clears active flag
// - active zero means data already in memory
// - pointer is 32 bits, low two read zero
// - regions taken from successive table entries
// - transaction stops after end-marked region
// - status at offsets 02h and 0Ah
// - pointer at offsets 04h and 0Ch
// - start on rising start bit; zero discards state
// - direction bit selects memory read or write
`timescale 1ns/100ps
module bms_engine
  import bms_pkg::*;
#(
  parameter logic SIMPLEX = 1'b0
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic [3:0]             io_addr_i,
  input  wire logic [3:0]             io_be_i,
  input  wire logic                   io_wr_i,
  input  wire logic                   io_rd_i,
  input  wire logic [31:0]            io_wdata_i,
  output logic      [31:0]            io_rdata_o,
  output logic                        io_rvalid_o,
  input  wire logic [bms_pkg::N_CH-1:0] drv_irq_i,
  output logic      [bms_pkg::N_CH-1:0] mem_req_o,
  output logic      [bms_pkg::N_CH-1:0] mem_we_o,
  output logic      [bms_pkg::N_CH-1:0][31:0] mem_addr_o,
  output logic      [bms_pkg::N_CH-1:0][31:0] mem_wdata_o,
  input  wire logic [bms_pkg::N_CH-1:0] mem_ack_i,
  input  wire logic [bms_pkg::N_CH-1:0] mem_err_i,
  input  wire logic [bms_pkg::N_CH-1:0][31:0] mem_rdata_i,
  input  wire logic [bms_pkg::N_CH-1:0][31:0] drv_wr_data_i,
  input  wire logic [bms_pkg::N_CH-1:0] drv_wr_valid_i,
  output logic      [bms_pkg::N_CH-1:0] drv_wr_ready_o,
  output logic      [bms_pkg::N_CH-1:0][31:0] drv_rd_data_o,
  output logic      [bms_pkg::N_CH-1:0] drv_rd_valid_o,
  input  wire logic [bms_pkg::N_CH-1:0] drv_rd_ready_i
);
  import bms_pkg::*;
  typedef struct packed {
    logic       [N_CH-1:0]       start;
    logic       [N_CH-1:0]       dir;
    logic       [N_CH-1:0]       drv1_cap;
    logic       [N_CH-1:0]       drv0_cap;
    logic       [N_CH-1:0]       intr;
    logic       [N_CH-1:0]       err;
    logic       [N_CH-1:0]       act;
    logic       [N_CH-1:0]       irq_s1;
    logic       [N_CH-1:0]       irq_s2;
    logic       [N_CH-1:0]       irq_prev;
    logic       [N_CH-1:0]       irq_pend;
    logic       [N_CH-1:0][29:0] ptr;
    logic       [N_CH-1:0][29:0] tbl;
    logic       [N_CH-1:0][29:0] addr;
    logic       [N_CH-1:0][14:0] cnt;
    logic       [N_CH-1:0]       end_of_table_flag;
    bms_state_t [N_CH-1:0]       fsm;
    logic       [N_CH-1:0]       mreq;
    logic       [N_CH-1:0]       mwe;
    logic       [N_CH-1:0][29:0] maddr;
    logic       [N_CH-1:0][31:0] mwdata;
    logic       [N_CH-1:0][31:0] rdata;
    logic       [N_CH-1:0]       rvld;
    logic       [31:0]           io_rdata;
    logic                        io_rvalid;
  } bms_regs_t;
  bms_regs_t q;
  bms_regs_t d;
  // dword slot of each channel: slot 2*ch holds command/status, 2*ch+1 the pointer
  function automatic logic slot_hit(input logic [3:0] a, input int unsigned ch,
                                    input logic ptr_slot);
    return a[3] == ch[0] && a[2] == ptr_slot;
  endfunction
  function automatic logic [7:0] status_byte(input bms_regs_t s, input int unsigned ch);
    status_byte = STATUS_RESET;
    status_byte[ST_SIMPLEX_BIT] = SIMPLEX;
    status_byte[ST_DRV1_BIT]    = s.drv1_cap[ch];
    status_byte[ST_DRV0_BIT]    = s.drv0_cap[ch];
    status_byte[ST_INT_BIT]     = s.intr[ch];
    status_byte[ST_ERR_BIT]     = s.err[ch];
    status_byte[ST_ACT_BIT]     = s.act[ch];
  endfunction
  logic [N_CH-1:0] wr_cmd;
  logic [N_CH-1:0] wr_st;
  logic [N_CH-1:0] irq_edge;
  logic [N_CH-1:0] mem_wr_busy;
  logic [N_CH-1:0] mem_done;
  logic [N_CH-1:0] mem_fail;
  logic [N_CH-1:0] region_end;
  logic [N_CH-1:0] take_drv;
  logic [7:0]      cmd_w;
  logic [7:0]      st_w;
  logic [15:0]     bytes;
  always_comb begin
    d = q;
    cmd_w = io_wdata_i[8*CMD_LANE +: 8];
    st_w = io_wdata_i[8*STATUS_LANE +: 8];
    bytes = 16'h0000;
    wr_cmd = '0;
    wr_st = '0;
    irq_edge = '0;
    mem_wr_busy = '0;
    mem_done = '0;
    mem_fail = '0;
    region_end = '0;
    take_drv = '0;
    d.io_rvalid = io_rd_i;
    d.io_rdata = 32'h0000_0000;
    for (int ch = 0; ch < N_CH; ch++) begin
      wr_cmd[ch] = io_wr_i && io_be_i[CMD_LANE] && slot_hit(io_addr_i, ch, 1'b0);
      wr_st[ch] = io_wr_i && io_be_i[STATUS_LANE] && slot_hit(io_addr_i, ch, 1'b0);

      // reads: reserved bits and lanes return zero
      if (io_rd_i && slot_hit(io_addr_i, ch, 1'b0)) begin
        d.io_rdata[8*CMD_LANE + CMD_START_BIT] = q.start[ch];
        d.io_rdata[8*CMD_LANE + CMD_DIR_BIT] = q.dir[ch];
        d.io_rdata[8*STATUS_LANE +: 8] = status_byte(q, ch);
      end
      if (io_rd_i && slot_hit(io_addr_i, ch, 1'b1)) begin
        d.io_rdata = {q.ptr[ch], 2'b00};
      end

      // pointer write, byte by byte
      if (io_wr_i && slot_hit(io_addr_i, ch, 1'b1)) begin
        for (int b = 0; b < 4; b++) begin
          if (io_be_i[b]) begin
            if (b == 0) begin
              d.ptr[ch][5:0] = io_wdata_i[7:2];
            end else begin
              d.ptr[ch][8*b-2 +: 8] = io_wdata_i[8*b +: 8];
            end
          end
        end
      end

      // drive pin: two flops, edge taken from the second only
      d.irq_s1[ch] = drv_irq_i[ch];
      d.irq_s2[ch] = q.irq_s1[ch];
      d.irq_prev[ch] = q.irq_s2[ch];
      irq_edge[ch] = q.irq_s2[ch] && !q.irq_prev[ch];

      // flag must not show before drive data has landed in memory
      mem_wr_busy[ch] = q.mreq[ch] && q.mwe[ch];
      if (irq_edge[ch] || q.irq_pend[ch]) begin
        if (mem_wr_busy[ch]) begin
          d.irq_pend[ch] = 1'b1;
        end else begin
          d.irq_pend[ch] = 1'b0;
        end
      end

      // status writes: capability flags stored, int/err write-one-to-clear
      if (wr_st[ch]) begin
        d.drv1_cap[ch] = st_w[ST_DRV1_BIT];
        d.drv0_cap[ch] = st_w[ST_DRV0_BIT];
        if (st_w[ST_INT_BIT]) begin
          d.intr[ch] = 1'b0;
        end
        if (st_w[ST_ERR_BIT]) begin
          d.err[ch] = 1'b0;
        end
      end
      // set wins over a same-cycle clear
      if ((irq_edge[ch] || q.irq_pend[ch]) && !mem_wr_busy[ch]) begin
        d.intr[ch] = 1'b1;
      end

      // memory port handshake
      mem_done[ch] = q.mreq[ch] && mem_ack_i[ch];
      mem_fail[ch] = mem_done[ch] && mem_err_i[ch];
      if (mem_done[ch]) begin
        d.mreq[ch] = 1'b0;
      end

      // drive stream, reading side
      if (q.rvld[ch] && drv_rd_ready_i[ch]) begin
        d.rvld[ch] = 1'b0;
      end

      case (q.fsm[ch])
        BMS_IDLE: begin
        end
        BMS_FETCH0: begin
          if (!q.mreq[ch]) begin
            d.mreq[ch] = 1'b1;
            d.mwe[ch] = 1'b0;
            d.maddr[ch] = q.tbl[ch];
          end else if (mem_done[ch] && !mem_fail[ch]) begin
            d.addr[ch] = mem_rdata_i[ch][31:2];
            // table never crosses its 64K block
            d.tbl[ch] = {q.tbl[ch][29:14], q.tbl[ch][13:0] + 14'h0001};
            d.fsm[ch] = BMS_FETCH1;
          end
        end
        BMS_FETCH1: begin
          if (!q.mreq[ch]) begin
            d.mreq[ch] = 1'b1;
            d.mwe[ch] = 1'b0;
            d.maddr[ch] = q.tbl[ch];
          end else if (mem_done[ch] && !mem_fail[ch]) begin
            bytes = mem_rdata_i[ch][15:0];
            // zero bytes means a full 64K region; odd tails round up a word
            if (bytes == 16'h0000) begin
              d.cnt[ch] = CNT_64K_WORDS;
            end else begin
              d.cnt[ch] = {1'b0, bytes[15:2]} + {14'h0000, |bytes[1:0]};
            end
            d.end_of_table_flag[ch] = mem_rdata_i[ch][DESC_EOT_BIT];
            d.tbl[ch] = {q.tbl[ch][29:14], q.tbl[ch][13:0] + 14'h0001};
            d.fsm[ch] = BMS_XFER;
          end
        end
        BMS_XFER: begin
          region_end[ch] = q.cnt[ch] == 15'h0000 && !q.mreq[ch] && !q.rvld[ch];
          if (region_end[ch]) begin
            if (q.end_of_table_flag[ch]) begin
              d.act[ch] = 1'b0;
              d.fsm[ch] = BMS_IDLE;
            end else begin
              d.fsm[ch] = BMS_FETCH0;
            end
          end else if (!q.mreq[ch] && q.cnt[ch] != 15'h0000) begin
            if (q.dir[ch]) begin
              // memory write: one drive word per request
              take_drv[ch] = drv_wr_valid_i[ch];
              if (drv_wr_valid_i[ch]) begin
                d.mreq[ch] = 1'b1;
                d.mwe[ch] = 1'b1;
                d.maddr[ch] = q.addr[ch];
                d.mwdata[ch] = drv_wr_data_i[ch];
              end
            end else if (!q.rvld[ch]) begin
              d.mreq[ch] = 1'b1;
              d.mwe[ch] = 1'b0;
              d.maddr[ch] = q.addr[ch];
            end
          end
          if (mem_done[ch] && !mem_fail[ch]) begin
            d.addr[ch] = q.addr[ch] + 30'h0000_0001;
            d.cnt[ch] = q.cnt[ch] - 15'h0001;
            if (!q.mwe[ch]) begin
              d.rdata[ch] = mem_rdata_i[ch];
              d.rvld[ch] = 1'b1;
            end
          end
        end
        default: begin
          d.fsm[ch] = BMS_IDLE;
        end
      endcase
      // a failed memory cycle ends the command
      if (mem_fail[ch]) begin
        d.err[ch] = 1'b1;
        d.act[ch] = 1'b0;
        d.fsm[ch] = BMS_IDLE;
      end

      // command writes come last so that a stop overrides the walker
      if (wr_cmd[ch]) begin
        d.start[ch] = cmd_w[CMD_START_BIT];
        if (!q.act[ch]) begin
          d.dir[ch] = cmd_w[CMD_DIR_BIT];
        end
        if (cmd_w[CMD_START_BIT] && !q.start[ch]) begin
          d.act[ch] = 1'b1;
          d.tbl[ch] = q.ptr[ch];
          d.fsm[ch] = BMS_FETCH0;
          d.mreq[ch] = 1'b0;
          d.rvld[ch] = 1'b0;
        end else if (!cmd_w[CMD_START_BIT]) begin
          // walker state, count, request, read word and pending interrupt dropped; a stopped command cannot resume
          d.act[ch] = 1'b0;
          d.fsm[ch] = BMS_IDLE;
          d.mreq[ch] = 1'b0;
          d.rvld[ch] = 1'b0;
          d.cnt[ch] = 15'h0000;
          d.irq_pend[ch] = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  always_comb begin
    for (int ch = 0; ch < N_CH; ch++) begin
      mem_addr_o[ch] = {q.maddr[ch], 2'b00};
    end
  end
  assign io_rdata_o     = q.io_rdata;
  assign io_rvalid_o    = q.io_rvalid;
  assign mem_req_o      = q.mreq;
  assign mem_we_o       = q.mwe;
  assign mem_wdata_o    = q.mwdata;
  assign drv_wr_ready_o = take_drv;
  assign drv_rd_data_o  = q.rdata;
  assign drv_rd_valid_o = q.rvld;
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_chk
      sequence start_rise_s;
        wr_cmd[g] && cmd_w[CMD_START_BIT] && !q.start[g];
      endsequence
      sequence status_read_s;
        io_rd_i && slot_hit(io_addr_i, g, 1'b0);
      endsequence
      simplex_ro_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        status_read_s |=> io_rdata_o[8*STATUS_LANE + ST_SIMPLEX_BIT] == SIMPLEX)
        else $error("simplex bit wrong");
      ptr_low_zero_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        io_rd_i && slot_hit(io_addr_i, g, 1'b1) |=> io_rdata_o == {$past(q.ptr[g]), 2'b00}
          && io_rdata_o[1:0] == 2'b00)
        else $error("pointer read wrong");
      int_set_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        irq_edge[g] && !mem_wr_busy[g] |=> q.intr[g])
        else $error("interrupt flag not set");
      int_commit_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(q.intr[g]) |-> !$past(mem_wr_busy[g]))
        else $error("interrupt flag before write done");
      err_set_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        mem_fail[g] |=> q.err[g] && !q.act[g] && q.fsm[g] == BMS_IDLE)
        else $error("error not flagged");
      err_keep_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        q.err[g] && !(wr_st[g] && st_w[ST_ERR_BIT]) |=> q.err[g])
        else $error("error flag lost");
      act_start_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        start_rise_s |=> q.act[g] && q.fsm[g] == BMS_FETCH0 ##1 q.mreq[g] && !q.mwe[g])
        else $error("start did not activate");
      act_stop_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        wr_cmd[g] && !cmd_w[CMD_START_BIT] |=> !q.act[g] && !q.mreq[g]
          && q.fsm[g] == BMS_IDLE)
        else $error("stop did not halt");
      eot_end_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        region_end[g] && q.end_of_table_flag[g] && !wr_cmd[g] |=> !q.act[g] ##1 !q.mreq[g])
        else $error("end region did not finish");
      next_desc_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        region_end[g] && !q.end_of_table_flag[g] && !wr_cmd[g] |=> q.fsm[g] == BMS_FETCH0 && q.act[g])
        else $error("next descriptor not fetched");
      dir_we_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        q.mreq[g] && q.fsm[g] == BMS_XFER |-> q.mwe[g] == q.dir[g])
        else $error("direction mismatch");
    end
  endgenerate
endmodule

// ===== hw/bms_pkg.sv
/*
  bms_pkg: constants, register layout and state encoding of the two-channel
  disk bus-master status / descriptor-pointer engine.
  assumes: byte offsets are relative to the bus-master I/O base decoded
  outside this block.
*/
package bms_pkg;

  localparam int unsigned N_CH = 2;

  // byte offsets within the I/O window
  localparam logic [3:0] PRI_CMD_OFS    = 4'h0;
  localparam logic [3:0] PRI_STATUS_OFS = 4'h2;
  localparam logic [3:0] PRI_PTR_OFS    = 4'h4;
  localparam logic [3:0] SEC_CMD_OFS    = 4'h8;
  localparam logic [3:0] SEC_STATUS_OFS = 4'ha;
  localparam logic [3:0] SEC_PTR_OFS    = 4'hc;

  // byte lanes inside a dword
  localparam int unsigned CMD_LANE    = 0;
  localparam int unsigned STATUS_LANE = 2;

  // command bits
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_DIR_BIT   = 3;

  // status bits
  localparam int unsigned ST_SIMPLEX_BIT = 7;
  localparam int unsigned ST_DRV1_BIT    = 6;
  localparam int unsigned ST_DRV0_BIT    = 5;
  localparam int unsigned ST_INT_BIT     = 2;
  localparam int unsigned ST_ERR_BIT     = 1;
  localparam int unsigned ST_ACT_BIT     = 0;

  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [31:0] PTR_RESET    = 32'h0000_0000;

  // descriptor entry: dword 0 region address, dword 1 byte count and end mark
  localparam int unsigned DESC_EOT_BIT  = 31;
  localparam logic [14:0] CNT_64K_WORDS = 15'h4000;

  typedef enum logic [2:0] {
    BMS_IDLE   = 3'b000,
    BMS_FETCH0 = 3'b001,
    BMS_FETCH1 = 3'b010,
    BMS_XFER   = 3'b011
  } bms_state_t;

endpackage
